// [pkg/ssb_cfg.svh]
// Timing and field constants for the snooze and burst order block
`ifndef SSB_CFG_SVH
`define SSB_CFG_SVH
`define SSB_CLK_PERIOD_NS 10
`define SSB_ENTRY_IGNORE_CYC 2
`define SSB_EXIT_RESUME_CYC 2
`define SSB_ENTRY_POWER_CYC 2
// One cycle passes before the entry counter starts, so it stops two short of the delay
`define SSB_ENTRY_WAIT_LAST (`SSB_ENTRY_POWER_CYC - 2)
`define SSB_EXIT_POWER_CYC 0
`define SSB_BURST_BEATS 4
`define SSB_BEAT_W 2
`define SSB_BEAT_LAST 2'h3
`define SSB_BEAT_ZERO 2'h0
`define SSB_BEAT_ONE 2'h1
`define SSB_CNT_ZERO 2'h0
`define SSB_CNT_ONE 2'h1
`endif

// [pkg/ssb_pkg.sv]
// Types for the snooze and burst order block
package ssb_pkg;
	typedef enum logic {SSB_ORDER_LINEAR, SSB_ORDER_INTERLEAVED} ssb_order_e;
	typedef enum logic [1:0] {SSB_AWAKE, SSB_ENTERING, SSB_SNOOZE} ssb_state_e;
	typedef struct packed {
		logic start;
		logic advance;
		logic [19:0] addr;
	} ssb_cmd_s;
	typedef struct packed {
		logic valid;
		logic [19:0] addr;
	} ssb_beat_s;
endpackage

// [verilog/ssb_burst_seq.sv]
// Four-beat burst address sequencer, interleaved or linear
`timescale 1ns/100ps
`include "ssb_cfg.svh"
module ssb_burst_seq
	import ssb_pkg::*;
#(
	parameter int ADDR_W = 20
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic start,
	input wire logic advance,
	input wire logic [ADDR_W-1:0] start_addr,
	input wire ssb_order_e order,
	// Beat address
	output logic [ADDR_W-1:0] beat_addr,
	output logic beat_active
);
	logic [ADDR_W-1:0] base_q, base_d;
	logic [`SSB_BEAT_W-1:0] cnt_q, cnt_d;
	ssb_order_e order_q, order_d;
	logic active_q, active_d;

	function automatic logic [`SSB_BEAT_W-1:0] low_bits(input logic [`SSB_BEAT_W-1:0] s,
		input logic [`SSB_BEAT_W-1:0] c, input ssb_order_e o);
		// Only the low pair changes, so the burst wraps inside its group
		low_bits = (o == SSB_ORDER_INTERLEAVED) ? (s ^ c) : `SSB_BEAT_W'(s + c);
	endfunction

	wire last_beat = (cnt_q == `SSB_BEAT_LAST);
	wire step = active_q && advance && !start;
	assign base_d = start ? start_addr : base_q;
	assign order_d = start ? order : order_q;
	assign cnt_d = start ? `SSB_CNT_ZERO : (step ? `SSB_BEAT_W'(cnt_q + `SSB_CNT_ONE) : cnt_q);
	assign active_d = start ? 1'h1 : ((step && last_beat) ? 1'h0 : active_q);
	assign beat_addr = {base_q[ADDR_W-1:`SSB_BEAT_W], low_bits(base_q[`SSB_BEAT_W-1:0], cnt_q, order_q)};
	assign beat_active = active_q;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			base_q <= '0;
			cnt_q <= `SSB_CNT_ZERO;
			order_q <= SSB_ORDER_INTERLEAVED;
			active_q <= 1'h0;
		end
		else
		begin
			base_q <= base_d;
			cnt_q <= cnt_d;
			order_q <= order_d;
			active_q <= active_d;
		end
	end
endmodule // ssb_burst_seq

// [verilog/ssb_snooze_burst.sv]
// Snooze entry and exit sequencing with burst address ordering
`timescale 1ns/100ps
`include "ssb_cfg.svh"

module ssb_snooze_burst
	import ssb_pkg::*;
#(
	parameter int ADDR_W = 20
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Pins from the memory controller
	input wire logic sleep_request,
	input wire logic burst_order_select,
	input wire ssb_cmd_s cmd,
	// Towards the memory core
	output ssb_beat_s core_beat,
	output logic core_snooze,
	output logic inputs_honoured
);
	// State and counters
	ssb_state_e state_q, state_d;
	logic [1:0] wait_q, wait_d;
	logic snooze_q, snooze_d;
	logic honour_q, honour_d;
	logic [1:0] resume_q, resume_d;
	ssb_beat_s beat_q, beat_d;

	// Sequencer hookup
	logic [ADDR_W-1:0] seq_addr;
	logic seq_active;

	// Counter steps for the entry (count_up) and resume (count_down) counters
	function automatic logic [1:0] count_up(input logic [1:0] v);
		count_up = 2'(v + `SSB_CNT_ONE);
	endfunction

	// Stops at zero so an idle resume counter never wraps
	function automatic logic [1:0] count_down(input logic [1:0] v);
		if (v == `SSB_CNT_ZERO)
			count_down = `SSB_CNT_ZERO;
		else
			count_down = 2'(v - `SSB_CNT_ONE);
	endfunction

	// Sleep pin
	wire sleep_on = sleep_request;
	wire sleep_off = !sleep_request;
	wire in_snooze = (state_q == SSB_SNOOZE);
	wire entry_done = (wait_q == 2'(`SSB_ENTRY_WAIT_LAST));
	wire [1:0] wait_next = count_up(wait_q);
	wire wake_edge = in_snooze && sleep_off;
	wire resume_idle = (resume_q == `SSB_CNT_ZERO);
	wire [1:0] resume_load = 2'(`SSB_EXIT_RESUME_CYC);

	// Burst order pin
	// An undriven select pin reads high at the pad, giving interleaved order
	wire ssb_order_e order_sel = burst_order_select ? SSB_ORDER_INTERLEAVED : SSB_ORDER_LINEAR;

	// Command gating
	// Commands count only outside snooze and after the resume gap
	wire cmd_ok = !in_snooze && resume_idle;
	wire seq_start = cmd_ok && cmd.start;
	wire seq_adv = cmd_ok && cmd.advance;
	wire [ADDR_W-1:0] seq_base = cmd.addr[ADDR_W-1:0];

	// Snooze state machine
	always_comb
	begin
		state_d = state_q;
		wait_d = wait_q;
		unique case (state_q)
			SSB_AWAKE:
			begin
				wait_d = `SSB_CNT_ZERO;
				if (sleep_on)
					state_d = SSB_ENTERING;
			end
			SSB_ENTERING:
			begin
				// Inputs still honoured here; snooze after the full delay
				if (sleep_off)
					state_d = SSB_AWAKE;
				else if (entry_done)
					state_d = SSB_SNOOZE;
				else
					wait_d = wait_next;
			end
			SSB_SNOOZE:
			begin
				if (sleep_off)
					state_d = SSB_AWAKE;
			end
			default:
				state_d = SSB_AWAKE;
		endcase
	end

	// Power state tracks the next state so release costs no cycle
	wire next_snooze = (state_d == SSB_SNOOZE);
	assign snooze_d = next_snooze;
	// Commands are refused in snooze and through the resume gap
	wire resume_clear = (resume_d == `SSB_CNT_ZERO);
	assign honour_d = !next_snooze && resume_clear;
	// Resume gap guards against a controller that breaks its wait
	assign resume_d = wake_edge ? resume_load :
		count_down(resume_q);
	// Valid drops on the snooze edge itself, never alongside snooze
	assign beat_d.valid = seq_active && !next_snooze;
	assign beat_d.addr = seq_addr;

	// Burst address sequencer
	ssb_burst_seq #(
		.ADDR_W(ADDR_W)
	) u_seq (
		.clk(clk),
		.srst(srst),
		.start(seq_start),
		.advance(seq_adv),
		.start_addr(seq_base),
		.order(order_sel),
		.beat_addr(seq_addr),
		.beat_active(seq_active)
	);

	// State register
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= SSB_AWAKE;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Entry counter
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wait_q <= `SSB_CNT_ZERO;
		end
		else
		begin
			wait_q <= wait_d;
		end
	end

	// Snooze power flag
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			snooze_q <= 1'h0;
		end
		else
		begin
			snooze_q <= snooze_d;
		end
	end

	// Command acceptance flag
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			honour_q <= 1'h1;
		end
		else
		begin
			honour_q <= honour_d;
		end
	end

	// Resume gap counter
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			resume_q <= `SSB_CNT_ZERO;
		end
		else
		begin
			resume_q <= resume_d;
		end
	end

	// Beat register
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			beat_q <= '0;
		end
		else
		begin
			beat_q <= beat_d;
		end
	end

	// Outputs come straight from their flip-flops
	assign core_snooze = snooze_q;
	assign inputs_honoured = honour_q;
	assign core_beat = beat_q;
endmodule // ssb_snooze_burst

// [testbench/ssb_chk.sv]
// Checker on the snooze block ports
`timescale 1ns/100ps
module ssb_chk
	import ssb_pkg::*;
(
	// Watched ports
	input wire logic clk,
	input wire logic srst,
	input wire logic sleep_request,
	input wire ssb_cmd_s cmd,
	input wire ssb_beat_s core_beat,
	input wire logic core_snooze,
	input wire logic inputs_honoured
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	still_on_a: assert property ($rose(sleep_request) && inputs_honoured |=> inputs_honoured) else $error("deaf");
	snooze_mute_a: assert property (core_snooze |-> !inputs_honoured && !core_beat.valid) else $error("mute");
	snooze_late_a: assert property (sleep_request[*3] |-> core_snooze) else $error("late");
	wake_now_a: assert property ($fell(sleep_request) |=> !core_snooze) else $error("wake");
	resume_gap_a: assert property ($fell(core_snooze) |-> !inputs_honoured) else $error("gap");
	upper_hold_a: assert property (core_beat.valid && $past(core_beat.valid) && !$past(cmd.start, 2)
		|-> $stable(core_beat.addr[19:2])) else $error("wrap");
	cover property (core_snooze);
	cover property ($fell(core_snooze));
	cover property ($rose(inputs_honoured));
	cover property (core_beat.valid ##1 !core_beat.valid);
endmodule // ssb_chk
bind ssb_snooze_burst ssb_chk chk_u(.*);

// [testbench/ssb_ctrl.sv]
// Memory controller model for the snooze block
`timescale 1ns/100ps
module ssb_ctrl
	import ssb_pkg::*;
(
	// Clock and pins to the block
	input wire logic clk,
	output logic sleep_request = 1'h0,
	output logic burst_order_select = 1'h1,
	output ssb_cmd_s cmd = '0
);
	task automatic sleep(logic on);
		@(posedge clk) sleep_request <= on;
	endtask
	task automatic burst(logic sel, logic [19:0] a);
		@(posedge clk) cmd <= '{1'h1, 1'h0, a};
		burst_order_select <= sel;
		@(posedge clk) cmd.start <= 1'h0;
	endtask
	task automatic step;
		@(posedge clk) cmd.advance <= 1'h1;
		@(posedge clk) cmd.advance <= 1'h0;
	endtask
endmodule // ssb_ctrl

// [testbench/ssb_snooze_burst_tb.sv]
// Self-checking bench for the snooze block
`timescale 1ns/100ps
module ssb_snooze_burst_tb
	import ssb_pkg::*;
;
	logic clk = 1'h0, srst = 1'h1, sleep_request, burst_order_select, core_snooze, inputs_honoured;
	ssb_cmd_s cmd;
	ssb_beat_s core_beat;
	int fail_count = 0, num_checks = 0;
	always #5 clk = ~clk;
	ssb_ctrl ctl_u(.*);
	ssb_snooze_burst dut_u(.*);
	task automatic chk(string n, logic [1:0] s, e);
		num_checks++;
		fail_count += (s !== e);
		if (s !== e) $display("CHECK FAILED %s exp %h got %h", n, e, s);
	endtask
	// Bounded, so a stuck burst still reaches the report
	task automatic beat(logic v, logic [1:0] lo);
		bit seen = 1'h0;
		for (int i = 0; i < 8 && !seen; i++)
		begin
			@(negedge clk);
			seen = (core_beat.valid === v && (!v || core_beat.addr[1:0] === lo));
		end
		chk("valid", core_beat.valid, v);
		if (v) chk("beat", core_beat.addr[1:0], lo);
		if (!seen) wrap_up();
	endtask
	task automatic burst_run(logic sel);
		ctl_u.burst(sel, 20'hABCD1);
		for (int k = 0; k < 4; k++)
		begin
			beat(1'h1, sel ? 2'h1 ^ k[1:0] : 2'h1 + k[1:0]);
			ctl_u.step();
		end
		beat(1'h0, 2'h0);
	endtask
	task automatic snooze_run;
		ctl_u.sleep(1'h1);
		repeat (3) @(negedge clk);
		chk("snooze", core_snooze, 1'h1);
		chk("honoured", inputs_honoured, 1'h0);
		ctl_u.burst(1'h1, 20'h12340);
		ctl_u.sleep(1'h0);
		repeat (2) @(negedge clk);
		chk("snooze", core_snooze, 1'h0);
		chk("honoured", inputs_honoured, 1'h0);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("honoured", inputs_honoured, 1'h1);
		chk("refused", core_beat.valid, 1'h0);
		burst_run(1'h0);
	endtask
	task automatic wrap_up;
		$display("checks %0d fails %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 1'h0;
		burst_run(1'h1);
		snooze_run();
		wrap_up();
	end
endmodule // ssb_snooze_burst_tb
